// ### rtl/csr_pkg.sv
// Package with constants, event carriers and state type of the status block.
package csr_pkg;

   // Status word bit positions.
   localparam int PSW_C = 0;
   localparam int PSW_T = 1;
   localparam int PSW_L = 2;
   localparam int PSW_U = 3;
   localparam int PSW_F = 5;
   localparam int PSW_Z = 6;
   localparam int PSW_N = 7;
   localparam int PSW_E = 9;
   localparam int PSW_P = 10;
   localparam int PSW_I = 11;

   // Values after reset and writable bit masks.
   localparam logic [15:0] PSW_RESET = 16'h0200;
   localparam logic [15:0] PSW_WMASK = 16'h0eef;
   localparam logic [15:0] CFG_RESET = 16'h0000;
   localparam logic [15:0] CFG_WMASK = 16'h0300;

   // Configuration bit positions.
   localparam int CFG_WD = 8;
   localparam int CFG_NR = 9;

   // Register byte offsets on the bus.
   localparam logic [7:0] OFF_PSW   = 8'h00;
   localparam logic [7:0] OFF_CFG   = 8'h04;
   localparam logic [7:0] OFF_SAVED = 8'h08;

   // Bus responses.
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Branch condition codes.
   localparam logic [3:0] CC_EQ = 4'h0;
   localparam logic [3:0] CC_NE = 4'h1;
   localparam logic [3:0] CC_CS = 4'h2;
   localparam logic [3:0] CC_CC = 4'h3;
   localparam logic [3:0] CC_HI = 4'h4;
   localparam logic [3:0] CC_LS = 4'h5;
   localparam logic [3:0] CC_GT = 4'h6;
   localparam logic [3:0] CC_LE = 4'h7;
   localparam logic [3:0] CC_FS = 4'h8;
   localparam logic [3:0] CC_FC = 4'h9;
   localparam logic [3:0] CC_LO = 4'ha;
   localparam logic [3:0] CC_HS = 4'hb;
   localparam logic [3:0] CC_LT = 4'hc;
   localparam logic [3:0] CC_GE = 4'hd;
   localparam logic [3:0] CC_AL = 4'he;

   // Events from the execution datapath and the exception sequencer.
   typedef struct packed {
      logic        instStart;
      logic        instEnd;
      logic        arithValid;
      logic        arithSub;
      logic        cmpValid;
      logic [15:0] opA;
      logic [15:0] opB;
      logic        enableIrq;
      logic        disableIrq;
      logic        jumpToUser;
      logic        excTaken;
      logic        excIsIrq;
      logic        excReturn;
      logic        retFromIrq;
      logic        retUser;
      logic        uspAccess;
      logic        condValid;
      logic [3:0]  cond;
   } csr_evt_t;

   // Whole state of the block.
   typedef struct packed {
      logic [15:0] psw;
      logic [15:0] cfg;
      logic [15:0] saved;
      logic        inHandler;
      logic        r2Load;
      logic        traceTrap;
      logic        undefinedOpTrap;
      logic        branchTaken;
      logic        branchValid;
      logic        irqEnable;
      logic        haveAw;
      logic        haveW;
      logic [7:0]  awAddr;
      logic [15:0] wData;
      logic [1:0]  wStrb;
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [1:0]  rresp;
      logic [15:0] rdata;
   } csr_state_t;

endpackage

// ### rtl/csr_status_config_regs.sv
// Processor status word and core configuration register logic.
//
// Contract
// - Add or subtract sets carry on carry or borrow, clears it otherwise.
// - Trace enabled gives a trace trap per instruction, none inside a handler.
// - Compare sets unsigned-low when second operand is below first, unsigned.
// - User bit selects user stack pointer, else supervisor stack pointer.
// - Exceptions force supervisor mode; user mode only via jump-to-user (here handler return and supervisor bus writes to status bit 3 also enter it).
// - User stack pointer access in user mode raises the undefined-op trap.
// - Add and subtract set the general flag on signed overflow.
// - Compare sets zero flag when operands equal, clears it otherwise.
// - Compare sets negative flag when second operand is below first, signed.
// - Maskable interrupts accepted only when local and global enables set.
// - Enable-irq instruction sets local enable; disable-irq clears it.
// - Trace copied to pending at start; trap only if pending at end.
// - Global enable cleared on interrupt entry, set on handler return (here only on a return with retFromIrq set).
// - Branch conditions decided from zero, carry, low, negative, flag.
// - Reset clears status bits 0 to 11 except local enable, which sets.
// - Warm reset copies the old status word into general register two.
// - Status bits 4 and 8 read zero; bits 12 to 15 reserved.
// - Status bits change only on instructions that affect them (here supervisor bus writes to the status word change them too).
// - Reset clears the whole configuration register.
// - Wide dispatch bit picks 16 or 32 bit table entries; base unaffected.
// - Narrow register mode uses 16-bit registers and paired return address.
//
// Added by the designer: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps

module csr_status_config_regs
   import csr_pkg::*;
#(
   parameter int ADDR_W = 32
) (
   input  wire logic              clk,
   input  wire logic              rst_b,
   input  wire logic              warmReset,
   input  wire csr_evt_t          evt,
   output logic                   userStackSelect,
   output logic                   maskableIrqEnable,
   output logic                   traceTrap,
   output logic                   undefinedOpTrap,
   output logic                   branchTaken,
   output logic                   branchValid,
   output logic                   wideDispatchSelect,
   output logic                   narrowRegisterMode,
   output logic                   loadGeneralRegisterTwo,
   output logic [15:0]            generalRegisterTwo,
   output logic [15:0]            statusWord,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready
);

   csr_state_t st;
   csr_state_t next_st;

   // Evaluates a branch condition against the flags of a status word.
   function automatic logic condMet(input logic [3:0] cc,
                                    input logic [15:0] p);
      logic r;
      r = 1'b0;
      case (cc)
         CC_EQ:   r = p[PSW_Z];
         CC_NE:   r = !p[PSW_Z];
         CC_CS:   r = p[PSW_C];
         CC_CC:   r = !p[PSW_C];
         CC_HI:   r = p[PSW_L] == 1'b0 && !p[PSW_Z] ? 1'b0 : p[PSW_L];
         CC_LS:   r = !p[PSW_L];
         CC_GT:   r = p[PSW_N];
         CC_LE:   r = !p[PSW_N];
         CC_FS:   r = p[PSW_F];
         CC_FC:   r = !p[PSW_F];
         CC_LO:   r = !p[PSW_L] && !p[PSW_Z];
         CC_HS:   r = p[PSW_L] || p[PSW_Z];
         CC_LT:   r = !p[PSW_N] && !p[PSW_Z];
         CC_GE:   r = p[PSW_N] || p[PSW_Z];
         CC_AL:   r = 1'b1;
         default: r = 1'b0;
      endcase
      return r;
   endfunction

   // Tells whether a byte address selects a mapped register.
   function automatic logic isMapped(input logic [7:0] a);
      return a == OFF_PSW || a == OFF_CFG || a == OFF_SAVED;
   endfunction

   // Next-state logic: datapath events, then software, then exceptions.
   always_comb begin
      logic [16:0] wideRes;
      logic [15:0] wm;
      wideRes = '0;
      wm = '0;
      next_st = st;
      next_st.r2Load = 1'b0;
      next_st.traceTrap = 1'b0;
      next_st.undefinedOpTrap = 1'b0;
      next_st.branchValid = 1'b0;

      // Arithmetic flags; the second operand is the destination.
      if (evt.arithValid) begin
         if (evt.arithSub) begin
            wideRes = {1'b0, evt.opB} - {1'b0, evt.opA};
            next_st.psw[PSW_F] = (evt.opB[15] != evt.opA[15]) &&
                                 (wideRes[15] != evt.opB[15]);
         end else begin
            wideRes = {1'b0, evt.opB} + {1'b0, evt.opA};
            next_st.psw[PSW_F] = (evt.opB[15] == evt.opA[15]) &&
                                 (wideRes[15] != evt.opB[15]);
         end
         next_st.psw[PSW_C] = wideRes[16];
      end

      // Comparison flags.
      if (evt.cmpValid) begin
         next_st.psw[PSW_Z] = evt.opA == evt.opB;
         next_st.psw[PSW_L] = evt.opB < evt.opA;
         next_st.psw[PSW_N] = $signed(evt.opB) < $signed(evt.opA);
      end

      // Local enable follows the enable and disable instructions.
      if (evt.enableIrq) begin
         next_st.psw[PSW_E] = 1'b1;
      end
      if (evt.disableIrq) begin
         next_st.psw[PSW_E] = 1'b0;
      end

      // Jump-to-user enters user mode; handler return and supervisor bus writes to bit 3 can too.
      if (evt.jumpToUser) begin
         next_st.psw[PSW_U] = 1'b1;
      end

      // Pending is armed at start, so one instruction traps only once.
      if (evt.instStart) begin
         next_st.psw[PSW_P] = st.psw[PSW_T] && !st.inHandler;
      end
      if (evt.instEnd && st.psw[PSW_P] && !st.inHandler) begin
         next_st.traceTrap = 1'b1;
         next_st.psw[PSW_P] = 1'b0;
      end

      // The user stack pointer is privileged.
      if (evt.uspAccess && st.psw[PSW_U]) begin
         next_st.undefinedOpTrap = 1'b1;
      end

      // Branch decision uses the flags standing before this cycle.
      if (evt.condValid) begin
         next_st.branchValid = 1'b1;
         next_st.branchTaken = condMet(evt.cond, st.psw);
      end

      // Handler return restores the mode the handler interrupted.
      if (evt.excReturn) begin
         next_st.inHandler = 1'b0;
         next_st.psw[PSW_U] = evt.retUser;
         if (evt.retFromIrq) begin
            next_st.psw[PSW_I] = 1'b1;
         end
      end

      // Write address and data are taken separately, in either order.
      if (s_axi_awvalid && st.awready) begin
         next_st.haveAw = 1'b1;
         next_st.awAddr = s_axi_awaddr[7:0];
      end
      if (s_axi_wvalid && st.wready) begin
         next_st.haveW = 1'b1;
         next_st.wData = s_axi_wdata[15:0];
         next_st.wStrb = s_axi_wstrb[1:0];
      end
      if (st.bvalid && s_axi_bready) begin
         next_st.bvalid = 1'b0;
      end

      // Perform a write once both halves are held; user mode is refused.
      if (st.haveAw && st.haveW && !st.bvalid) begin
         next_st.haveAw = 1'b0;
         next_st.haveW = 1'b0;
         next_st.bvalid = 1'b1;
         next_st.bresp = RESP_OKAY;
         wm = {{8{st.wStrb[1]}}, {8{st.wStrb[0]}}};
         if (!isMapped(st.awAddr) || st.psw[PSW_U]) begin
            next_st.bresp = RESP_SLVERR;
         end else if (st.awAddr == OFF_PSW) begin
            wm = wm & PSW_WMASK;
            next_st.psw = (next_st.psw & ~wm) | (st.wData & wm);
         end else if (st.awAddr == OFF_CFG) begin
            wm = wm & CFG_WMASK;
            next_st.cfg = (st.cfg & ~wm) | (st.wData & wm);
         end
      end

      // Reads answer one cycle after the address is taken.
      if (st.rvalid && s_axi_rready) begin
         next_st.rvalid = 1'b0;
      end
      if (s_axi_arvalid && st.arready) begin
         next_st.rvalid = 1'b1;
         next_st.rresp = RESP_OKAY;
         case (s_axi_araddr[7:0])
            OFF_PSW:   next_st.rdata = st.psw & PSW_WMASK;
            OFF_CFG:   next_st.rdata = st.cfg & CFG_WMASK;
            OFF_SAVED: next_st.rdata = st.saved;
            default: begin
               next_st.rdata = '0;
               next_st.rresp = RESP_SLVERR;
            end
         endcase
      end

      // Exception entry wins over every other status change except warm reset.
      if (evt.excTaken) begin
         next_st.inHandler = 1'b1;
         next_st.psw[PSW_U] = 1'b0;
         next_st.psw[PSW_P] = 1'b0;
         if (evt.excIsIrq) begin
            next_st.psw[PSW_I] = 1'b0;
         end
      end

      // Warm reset saves the old word and reloads the reset values.
      if (warmReset) begin
         next_st.saved = st.psw;
         next_st.r2Load = 1'b1;
         next_st.psw = PSW_RESET;
         next_st.cfg = CFG_RESET;
         next_st.inHandler = 1'b0;
      end

      // Reserved and constant bits never hold ones.
      next_st.psw = next_st.psw & PSW_WMASK;
      next_st.cfg = next_st.cfg & CFG_WMASK;

      // Ready flags are registered, so they look at the next state.
      next_st.awready = !next_st.haveAw && !next_st.bvalid;
      next_st.wready = !next_st.haveW && !next_st.bvalid;
      next_st.arready = !next_st.rvalid;
      next_st.irqEnable = next_st.psw[PSW_E] &&
                          next_st.psw[PSW_I];
   end

   // State register; cold reset loads the documented reset values.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st <= '0;
         st.psw <= PSW_RESET;
         st.cfg <= CFG_RESET;
         st.awready <= 1'b1;
         st.wready <= 1'b1;
         st.arready <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   // Outputs come straight from state flip-flops.
   assign userStackSelect = st.psw[PSW_U];
   assign maskableIrqEnable = st.irqEnable;
   assign traceTrap = st.traceTrap;
   assign undefinedOpTrap = st.undefinedOpTrap;
   assign branchTaken = st.branchTaken;
   assign branchValid = st.branchValid;
   assign wideDispatchSelect = st.cfg[CFG_WD];
   assign narrowRegisterMode = st.cfg[CFG_NR];
   assign loadGeneralRegisterTwo = st.r2Load;
   assign generalRegisterTwo = st.saved;
   assign statusWord = st.psw;
   assign s_axi_awready = st.awready;
   assign s_axi_wready = st.wready;
   assign s_axi_bvalid = st.bvalid;
   assign s_axi_bresp = st.bresp;
   assign s_axi_arready = st.arready;
   assign s_axi_rvalid = st.rvalid;
   assign s_axi_rresp = st.rresp;
   assign s_axi_rdata = {16'h0000, st.rdata};

endmodule // csr_status_config_regs

// ### tb/csr_status_config_assertions.sv
// Concurrent checks on the ports of the status register block.
`timescale 1ns/1ps
module csr_status_config_assertions
   import csr_pkg::*;
(
   input wire logic        clk,
   input wire logic        rst_b,
   input wire logic        warmReset,
   input wire csr_evt_t    evt,
   input wire logic        userStackSelect,
   input wire logic        maskableIrqEnable,
   input wire logic        traceTrap,
   input wire logic        undefinedOpTrap,
   input wire logic        loadGeneralRegisterTwo,
   input wire logic [15:0] generalRegisterTwo,
   input wire logic [15:0] statusWord,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wready
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   // Bus writes and warm reset outrank flag events, so skip them; handler returns are skipped as well.
   logic        quiet, cy, eq, lo, ng;
   logic [16:0] sum;
   assign sum = {1'b0, evt.opB} + {1'b0, evt.opA};
   assign cy = sum[16];
   assign eq = evt.opA == evt.opB;
   assign lo = evt.opB < evt.opA;
   assign ng = $signed(evt.opB) < $signed(evt.opA);
   assign quiet = s_axi_awready && s_axi_wready && !warmReset
                  && !evt.excReturn;
   a_carry_add: assert property (quiet && evt.arithValid
      && !evt.arithSub |=> statusWord[PSW_C] == $past(cy))
      else $error("carry after add is wrong");
   a_borrow_sub: assert property (quiet && evt.arithValid
      && evt.arithSub |=> statusWord[PSW_C] == $past(lo))
      else $error("borrow after subtract is wrong");
   a_compare_flags: assert property (quiet && evt.cmpValid |=>
      statusWord[PSW_Z] == $past(eq) && statusWord[PSW_L] == $past(lo)
      && statusWord[PSW_N] == $past(ng)) else $error("compare flags wrong");
   a_exc_supervisor: assert property (evt.excTaken && !warmReset
      |=> !userStackSelect) else $error("exception kept user mode");
   a_irq_global_off: assert property (evt.excTaken && evt.excIsIrq
      && !warmReset |=> !statusWord[PSW_I] && !maskableIrqEnable)
      else $error("interrupt entry kept global enable");
   a_usp_trap: assert property (evt.uspAccess && userStackSelect
      && !warmReset |=> undefinedOpTrap)
      else $error("no trap on user stack access");
   a_trace_cause: assert property (traceTrap |->
      $past(evt.instEnd) && $past(statusWord[PSW_P]))
      else $error("trace trap without pending end");
   a_warm_copy: assert property (warmReset |=>
      statusWord == PSW_RESET && generalRegisterTwo == $past(statusWord)
      && loadGeneralRegisterTwo) else $error("warm reset copy wrong");
   // Main scenarios seen at least once.
   c_trace: cover property (traceTrap);
   c_usp: cover property (undefinedOpTrap);
   c_warm: cover property (loadGeneralRegisterTwo);
endmodule // csr_status_config_assertions

// ### tb/csr_exec_model.sv
// Behavioural execution datapath that issues event pulses to the block.
`timescale 1ns/1ps
module csr_exec_model
   import csr_pkg::*;
(
   input  wire logic clk,
   output csr_evt_t  evt
);
   initial evt = '0;
   // One-cycle pulse; operands then flip so stale data never looks valid.
   task automatic send(input csr_evt_t e);
      @(posedge clk);
      evt <= e;
      @(posedge clk);
      evt <= '{opA: ~e.opA, opB: ~e.opB, cond: ~e.cond, default: '0};
      #1;
   endtask
   // Handler placement is software's job; no dispatch fetch is modelled.
   // With narrow entries every handler is assumed below 128K.
   // Add, subtract or compare; a is the first operand, b the second.
   task automatic alu(input logic c, input logic s,
                      input logic [15:0] a, input logic [15:0] b);
      send('{arithValid: !c, arithSub: s, cmpValid: c, opA: a, opB: b,
             default: '0});
   endtask
endmodule // csr_exec_model

// ### tb/csr_status_config_regs_bench.sv
// Self-checking bench for the status and configuration registers.
`timescale 1ns/1ps
module csr_status_config_regs_bench;
   import csr_pkg::*;
   logic        clk, rst_b, warmReset, userStackSelect, maskableIrqEnable;
   logic        traceTrap, undefinedOpTrap, branchTaken, branchValid;
   logic        wideDispatchSelect, narrowRegisterMode;
   logic        loadGeneralRegisterTwo;
   logic [15:0] generalRegisterTwo, statusWord, rd;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready;
   csr_evt_t    evt;
   int          fail_count, samples_checked;
   csr_status_config_regs dut (.*);
   csr_exec_model model (.clk, .evt);
   // Free-running clock.
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   // One bus transfer; each channel drops valid once it is taken.
   task automatic bus(input logic wr, input logic [7:0] a,
                      input logic [15:0] d);
      int n;
      n = 0;
      @(posedge clk);
      s_axi_awaddr <= {24'h00_0000, a};
      s_axi_araddr <= {24'h00_0000, a};
      s_axi_wdata <= {16'h0000, d};
      s_axi_awvalid <= wr;
      s_axi_wvalid <= wr;
      s_axi_bready <= wr;
      s_axi_arvalid <= !wr;
      s_axi_rready <= !wr;
      do begin
         @(posedge clk);
         n++;
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!(wr ? s_axi_bvalid : s_axi_rvalid) && n < 40);
      rd = s_axi_rdata[15:0];
      rsp = wr ? s_axi_bresp : s_axi_rresp;
      s_axi_bready <= 1'b0;
      s_axi_rready <= 1'b0;
      if (n >= 40) begin
         fail_count++;
         $display("BAD %0t bus answer never came", $time);
         tally_and_finish();
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // Reset values, configuration bits and an unmapped read.
   task automatic t_regs;
      bus(1'b0, OFF_PSW, 16'h0000);
      check(rd, 16'h0200);
      bus(1'b0, OFF_CFG, 16'h0000);
      check(rd, 16'h0000);
      bus(1'b1, OFF_CFG, 16'h0300);
      check(16'(rsp), 16'(RESP_OKAY));
      bus(1'b0, OFF_CFG, 16'h0000);
      check(rd, 16'h0300);
      check(16'(narrowRegisterMode), 16'h0001);
      bus(1'b1, OFF_CFG, 16'h0100);
      check(16'(wideDispatchSelect), 16'h0001);
      check(16'(narrowRegisterMode), 16'h0000);
      bus(1'b0, 8'h10, 16'h0000);
      check(16'(rsp), 16'(RESP_SLVERR));
   endtask
   // Carry and overflow on boundaries, compare flags, branch decisions.
   task automatic t_flags;
      model.alu(1'b0, 1'b0, 16'h0001, 16'hffff);
      check(statusWord & 16'h0021, 16'h0001);
      model.alu(1'b0, 1'b0, 16'h0001, 16'h7fff);
      check(statusWord & 16'h0021, 16'h0020);
      model.alu(1'b0, 1'b1, 16'h0002, 16'h0001);
      check(statusWord & 16'h0021, 16'h0001);
      model.alu(1'b0, 1'b1, 16'h0001, 16'h8000);
      check(statusWord & 16'h0021, 16'h0020);
      model.send('{enableIrq: 1'b1, default: '0});
      check(statusWord & 16'h0021, 16'h0020);
      model.alu(1'b1, 1'b0, 16'h0005, 16'h0005);
      check(statusWord & 16'h00c4, 16'h0040);
      model.alu(1'b1, 1'b0, 16'h0005, 16'h0003);
      check(statusWord & 16'h00c4, 16'h0084);
      model.alu(1'b1, 1'b0, 16'h0001, 16'h8000);
      check(statusWord & 16'h00c4, 16'h0080);
      model.alu(1'b1, 1'b0, 16'h8000, 16'h0001);
      check(statusWord & 16'h00c4, 16'h0004);
      model.send('{condValid: 1'b1, cond: CC_EQ, default: '0});
      check(16'({branchValid, branchTaken}), 16'h0002);
      model.alu(1'b1, 1'b0, 16'h1234, 16'h1234);
      model.send('{condValid: 1'b1, cond: CC_EQ, default: '0});
      check(16'({branchValid, branchTaken}), 16'h0003);
      model.send('{condValid: 1'b1, cond: CC_NE, default: '0});
      check(16'({branchValid, branchTaken}), 16'h0002);
   endtask
   // Interrupt enables, user mode and exception entry and return.
   task automatic t_modes;
      model.send('{disableIrq: 1'b1, default: '0});
      check(statusWord & 16'h0200, 16'h0000);
      model.send('{enableIrq: 1'b1, default: '0});
      check(16'(maskableIrqEnable), 16'h0000);
      bus(1'b1, OFF_PSW, 16'h0a00);
      check(16'(maskableIrqEnable), 16'h0001);
      model.send('{excTaken: 1'b1, excIsIrq: 1'b1, default: '0});
      check(16'(maskableIrqEnable), 16'h0000);
      model.send('{excReturn: 1'b1, retFromIrq: 1'b1, default: '0});
      check(statusWord & 16'h0a08, 16'h0a00);
      model.send('{jumpToUser: 1'b1, default: '0});
      check(16'(userStackSelect), 16'h0001);
      model.send('{uspAccess: 1'b1, default: '0});
      check(16'(undefinedOpTrap), 16'h0001);
      bus(1'b1, OFF_PSW, 16'h0000);
      check(16'(rsp), 16'(RESP_SLVERR));
      check(16'(userStackSelect), 16'h0001);
      model.send('{excTaken: 1'b1, default: '0});
      check(statusWord & 16'h0808, 16'h0800);
      model.send('{uspAccess: 1'b1, default: '0});
      check(16'(undefinedOpTrap), 16'h0000);
      model.send('{excReturn: 1'b1, default: '0});
   endtask
   // Trace pending and trap, then no trap inside a handler.
   task automatic t_trace;
      bus(1'b1, OFF_PSW, 16'h0202);
      model.send('{instStart: 1'b1, default: '0});
      check(statusWord & 16'h0400, 16'h0400);
      model.send('{instEnd: 1'b1, default: '0});
      check(16'(traceTrap), 16'h0001);
      model.send('{excTaken: 1'b1, default: '0});
      model.send('{instStart: 1'b1, default: '0});
      model.send('{instEnd: 1'b1, default: '0});
      check(16'(traceTrap), 16'h0000);
      model.send('{excReturn: 1'b1, default: '0});
   endtask
   // Warm reset keeps the old status word and restores reset values.
   task automatic t_warm;
      bus(1'b1, OFF_CFG, 16'h0300);
      @(posedge clk);
      warmReset <= 1'b1;
      @(posedge clk);
      warmReset <= 1'b0;
      #1;
      check(generalRegisterTwo, 16'h0202);
      check(16'(loadGeneralRegisterTwo), 16'h0001);
      check(statusWord, 16'h0200);
      check(16'(wideDispatchSelect), 16'h0000);
   endtask
   initial begin
      {rst_b, warmReset, s_axi_awvalid, s_axi_wvalid} = 4'h0;
      {s_axi_bready, s_axi_arvalid, s_axi_rready} = 3'h0;
      s_axi_awaddr = 32'h0000_0000;
      s_axi_araddr = 32'h0000_0000;
      s_axi_wdata = 32'h0000_0000;
      s_axi_wstrb = 4'hf;
      fail_count = 0;
      samples_checked = 0;
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      t_regs();
      t_flags();
      t_modes();
      t_trace();
      t_warm();
      tally_and_finish();
   end
endmodule // csr_status_config_regs_bench
bind csr_status_config_regs csr_status_config_assertions chk (.*);
